// [src/csi_core.v]
`timescale 1ns/10ps
`default_nettype none
`include "csi_consts.vh"

module csi_core (
	// Clock and reset
	input wire clock_i,
	input wire rst_n_i,
	// Register file ports for the ALU
	input wire [4:0] rf_rd_a_addr_i,
	input wire [4:0] rf_rd_b_addr_i,
	input wire [3:0] rf_rd_w_pair_i,
	input wire rf_wr_en_i,
	input wire rf_wr_wide_i,
	input wire [4:0] rf_wr_addr_i,
	input wire [15:0] rf_wr_data_i,
	output wire [7:0] rf_rd_a_o,
	output wire [7:0] rf_rd_b_o,
	output wire [15:0] rf_rd_w_o,
	// Data space access
	input wire [15:0] ds_addr_i,
	input wire ds_wr_i,
	input wire [7:0] ds_wdata_i,
	output wire ds_hit_o,
	output wire [7:0] ds_rdata_o,
	// Pointer addressing
	input wire ptr_go_i,
	input wire [1:0] ptr_sel_i,
	input wire [1:0] ptr_mode_i,
	input wire [5:0] ptr_disp_i,
	output wire [15:0] ptr_ea_o,
	// I/O register access
	input wire [5:0] io_addr_i,
	input wire io_wr_i,
	input wire io_rd_i,
	input wire [7:0] io_wdata_i,
	input wire [6:0] alu_flags_i,
	output reg [7:0] io_rdata_o,
	// Instruction stream
	input wire instr_bound_i,
	input wire op_push_i,
	input wire op_pop_i,
	input wire op_call_i,
	input wire op_ret_i,
	input wire op_irq_return_op_i,
	input wire op_sei_i,
	input wire op_cli_i,
	input wire sleeping_i,
	input wire [11:0] pc_i,
	input wire [7:0] push_data_i,
	// Stack memory
	output reg stk_we_o,
	output reg stk_re_o,
	output reg [15:0] stk_addr_o,
	output reg [7:0] stk_wdata_o,
	input wire [7:0] stk_rdata_i,
	// Interrupt sources and boot settings
	input wire [`CSI_NIRQ-1:0] irq_event_i,
	input wire [`CSI_NIRQ-1:0] irq_level_i,
	input wire [`CSI_NIRQ-1:0] irq_enable_i,
	input wire [`CSI_NIRQ-1:0] irq_flag_w1c_i,
	input wire boot_reset_fuse_i,
	input wire app_lock_setting_i,
	input wire boot_lock_setting_i,
	output reg [`CSI_NIRQ-1:0] irq_flags_o,
	// Program flow
	output wire core_hold_o,
	output reg pc_load_o,
	output reg [11:0] pc_load_addr_o,
	output wire [11:0] reset_vec_o,
	output wire global_irq_en_o,
	output wire [15:0] sp_o
);

	// One-hot sequencer states.
	localparam [3:0] S_RUN = 4'h1;
	localparam [3:0] S_WAKE = 4'h2;
	localparam [3:0] S_ENTER = 4'h4;
	localparam [3:0] S_IRQ_RETURN_OP = 4'h8;
	localparam N = `CSI_NIRQ;

	reg [7:0] rf_reg [0:31];
	reg [15:0] sp_reg;
	reg [15:0] sp_next;
	reg gie_reg;
	reg gie_next;
	reg vector_relocate_bit_reg;
	reg skip_reg;
	reg [3:0] state_reg;
	reg [2:0] cnt_reg;
	reg [7:0] win_reg;
	reg [11:0] pcsave_reg;
	reg [7:0] ret_hi_reg;
	wire [N-1:0] flag_next;
	wire [N-1:0] req;
	wire [N-1:0] grant;
	wire [7:0] win_idx;
	wire any_req;
	wire run;
	wire take;
	wire blocked;
	wire pc_in_boot;
	wire [4:0] ptr_lo;
	wire [15:0] ptr_val;
	wire [15:0] ptr_next;
	wire [11:0] vec_base;
	wire entry_done;
	wire irq_return_op_done;
	integer i;

	// Reads are plain muxes off the flops so the ALU sees operands early.
	assign rf_rd_a_o = rf_reg[rf_rd_a_addr_i];
	assign rf_rd_b_o = rf_reg[rf_rd_b_addr_i];
	assign rf_rd_w_o = {rf_reg[{rf_rd_w_pair_i, 1'b1}],
		rf_reg[{rf_rd_w_pair_i, 1'b0}]};

	// Data addresses up to the top register hit the file, not SRAM.
	assign ds_hit_o = (ds_addr_i <= `CSI_REG_TOP);
	assign ds_rdata_o = ds_hit_o ? rf_reg[ds_addr_i[4:0]] : 8'h00;

	// Pointer pair select; an unused select code falls back to Z.
	assign ptr_lo = (ptr_sel_i == 2'h0) ? `CSI_X_LO :
		(ptr_sel_i == 2'h1) ? `CSI_Y_LO : `CSI_Z_LO;
	assign ptr_val = {rf_reg[ptr_lo | 5'h01], rf_reg[ptr_lo]};

	csi_ptr_step u_ptr (
		.ptr_i(ptr_val),
		.mode_i(ptr_mode_i),
		.disp_i(ptr_disp_i),
		.ea_o(ptr_ea_o),
		.next_o(ptr_next)
	);

	// Register file writes. Later statements win, so a pointer
	// write-back beats a data store, which beats the ALU result.
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (i = 0; i < 32; i = i + 1) begin
				rf_reg[i] <= 8'h00;
			end
		end else begin
			if (rf_wr_en_i && rf_wr_wide_i) begin
				rf_reg[{rf_wr_addr_i[4:1], 1'b0}] <= rf_wr_data_i[7:0];
				rf_reg[{rf_wr_addr_i[4:1], 1'b1}] <= rf_wr_data_i[15:8];
			end else if (rf_wr_en_i) begin
				rf_reg[rf_wr_addr_i] <= rf_wr_data_i[7:0];
			end
			if (ds_wr_i && ds_hit_o) begin
				rf_reg[ds_addr_i[4:0]] <= ds_wdata_i;
			end
			if (ptr_go_i && (ptr_mode_i == `CSI_PM_POSTINC ||
				ptr_mode_i == `CSI_PM_PREDEC)) begin
				rf_reg[ptr_lo] <= ptr_next[7:0];
				rf_reg[ptr_lo | 5'h01] <= ptr_next[15:8];
			end
		end
	end

	// Interrupt selection. Level-type sources bypass the flags, so a
	// condition gone before enabling leaves nothing behind.
	assign pc_in_boot = (pc_i >= `CSI_BOOT_START);
	assign blocked = (app_lock_setting_i && !pc_in_boot &&
		vector_relocate_bit_reg) || (boot_lock_setting_i &&
		pc_in_boot && !vector_relocate_bit_reg);
	assign req = ((irq_flags_o & ~`CSI_LEVEL_MASK) |
		(irq_level_i & `CSI_LEVEL_MASK)) & irq_enable_i &
		{N{~blocked}};

	csi_irq_pick #(
		.N(N)
	) u_pick (
		.req_i(req),
		.grant_o(grant),
		.index_o(win_idx),
		.any_o(any_req)
	);

	assign run = (state_reg == S_RUN);
	assign core_hold_o = !run;
	assign take = run && instr_bound_i && gie_reg && !op_cli_i &&
		!op_irq_return_op_i && !skip_reg && any_req;
	assign entry_done = (state_reg == S_ENTER) &&
		(cnt_reg == `CSI_ENTRY_LAST);
	assign irq_return_op_done = (state_reg == S_IRQ_RETURN_OP) &&
		(cnt_reg == `CSI_IRQ_RETURN_OP_LAST);

	// Hardware clears only the winner's flag; a new event in the same
	// cycle as any clear sets the flag again.
	assign flag_next = (irq_flags_o & ~(irq_flag_w1c_i |
		(take ? grant : {N{1'b0}}))) |
		(irq_event_i & ~`CSI_LEVEL_MASK);

	// Vector table base and the reset vector.
	assign vec_base = vector_relocate_bit_reg ? `CSI_BOOT_START :
		`CSI_APP_START;
	assign reset_vec_o = boot_reset_fuse_i ? `CSI_BOOT_START :
		`CSI_APP_START;
	assign global_irq_en_o = gie_reg;
	assign sp_o = sp_reg;

	// Stack pointer next value. Only the enable bit of the status
	// register is ever touched by entry and return.
	always @* begin
		sp_next = sp_reg;
		if (state_reg == S_ENTER && cnt_reg < 3'h2) begin
			sp_next = sp_reg - 16'h0001;
		end else if (state_reg == S_IRQ_RETURN_OP && cnt_reg < 3'h2) begin
			sp_next = sp_reg + 16'h0001;
		end else if (run && op_push_i) begin
			sp_next = sp_reg - 16'h0001;
		end else if (run && op_pop_i) begin
			sp_next = sp_reg + 16'h0001;
		end else if (run && op_call_i) begin
			sp_next = sp_reg - 16'h0002;
		end else if (run && op_ret_i) begin
			sp_next = sp_reg + 16'h0002;
		end
		if (io_wr_i && io_addr_i == `CSI_IO_SPL) begin
			sp_next[7:0] = io_wdata_i;
		end
		if (io_wr_i && io_addr_i == `CSI_IO_SPH) begin
			sp_next[15:8] = io_wdata_i;
		end
	end

	// Global enable next value; the clear on entry is ordered after a
	// software write so a taken interrupt always leaves it off.
	always @* begin
		gie_next = gie_reg;
		if (io_wr_i && io_addr_i == `CSI_IO_STATUS_REG) begin
			gie_next = io_wdata_i[`CSI_GIE_BIT];
		end
		if (op_sei_i) begin
			gie_next = 1'b1;
		end
		if (op_cli_i) begin
			gie_next = 1'b0;
		end
		if (take) begin
			gie_next = 1'b0;
		end
		if (irq_return_op_done) begin
			gie_next = 1'b1;
		end
	end

	// Core registers, interrupt flags and the I/O read port.
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sp_reg <= `CSI_SP_RST;
			gie_reg <= 1'b0;
			vector_relocate_bit_reg <= `CSI_VECTOR_RELOCATE_BIT_RST;
			irq_flags_o <= {N{1'b0}};
			io_rdata_o <= 8'h00;
		end else begin
			sp_reg <= sp_next & `CSI_SP_MASK;
			gie_reg <= gie_next;
			irq_flags_o <= flag_next;
			if (io_wr_i && io_addr_i == `CSI_IO_GENERAL_IRQ_CONTROL_REG) begin
				vector_relocate_bit_reg <= io_wdata_i[`CSI_VECTOR_RELOCATE_BIT_BIT];
			end
			if (io_rd_i) begin
				case (io_addr_i)
				`CSI_IO_SPL: io_rdata_o <= sp_reg[7:0];
				`CSI_IO_SPH: io_rdata_o <= sp_reg[15:8];
				`CSI_IO_STATUS_REG: io_rdata_o <= {gie_reg, alu_flags_i};
				`CSI_IO_GENERAL_IRQ_CONTROL_REG: io_rdata_o <= {6'h00,
					vector_relocate_bit_reg, 1'b0};
				default: io_rdata_o <= 8'h00;
				endcase
			end
		end
	end

	// Sequencer for wake, entry and return. A pending request is only
	// taken at an instruction boundary, so a multi-cycle instruction
	// always finishes first.
	always @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= S_RUN;
			cnt_reg <= 3'h0;
			win_reg <= 8'h00;
			pcsave_reg <= 12'h000;
			ret_hi_reg <= 8'h00;
			skip_reg <= 1'b0;
			stk_we_o <= 1'b0;
			stk_re_o <= 1'b0;
			stk_addr_o <= 16'h0000;
			stk_wdata_o <= 8'h00;
			pc_load_o <= 1'b0;
			pc_load_addr_o <= 12'h000;
		end else begin
			stk_we_o <= 1'b0;
			stk_re_o <= 1'b0;
			pc_load_o <= 1'b0;
			cnt_reg <= cnt_reg + 3'h1;
			// One instruction must run after sei sets the enable, or after return.
			if (run && op_sei_i && !gie_reg) begin
				skip_reg <= 1'b1;
			end else if (irq_return_op_done) begin
				skip_reg <= 1'b1;
			end else if (run && instr_bound_i) begin
				skip_reg <= 1'b0;
			end
			case (state_reg)
			S_RUN: begin
				cnt_reg <= 3'h0;
				if (take) begin
					win_reg <= win_idx;
					pcsave_reg <= pc_i;
					state_reg <= sleeping_i ? S_WAKE : S_ENTER;
				end else if (instr_bound_i && op_irq_return_op_i) begin
					state_reg <= S_IRQ_RETURN_OP;
				end
				if (op_push_i) begin
					stk_we_o <= 1'b1;
					stk_addr_o <= sp_reg;
					stk_wdata_o <= push_data_i;
				end else if (op_pop_i) begin
					stk_re_o <= 1'b1;
					stk_addr_o <= sp_reg + 16'h0001;
				end
			end
			S_WAKE: begin
				if (cnt_reg == `CSI_WAKE_LAST) begin
					cnt_reg <= 3'h0;
					state_reg <= S_ENTER;
				end
			end
			S_ENTER: begin
				if (cnt_reg < 3'h2) begin
					stk_we_o <= 1'b1;
					stk_addr_o <= sp_reg;
					stk_wdata_o <= (cnt_reg == 3'h0) ? pcsave_reg[7:0] :
						{4'h0, pcsave_reg[11:8]};
				end
				if (entry_done) begin
					pc_load_o <= 1'b1;
					pc_load_addr_o <= vec_base + {4'h0, win_reg} +
						`CSI_VEC_STRIDE;
					state_reg <= S_RUN;
				end
			end
			S_IRQ_RETURN_OP: begin
				// Synchronous stack memory: data follows the strobe by
				// one cycle, high byte first as it was pushed last.
				if (cnt_reg < 3'h2) begin
					stk_re_o <= 1'b1;
					stk_addr_o <= sp_reg + 16'h0001;
				end
				if (cnt_reg == 3'h2) begin
					ret_hi_reg <= stk_rdata_i;
				end
				if (irq_return_op_done) begin
					pc_load_o <= 1'b1;
					pc_load_addr_o <= {ret_hi_reg[3:0], stk_rdata_i};
					state_reg <= S_RUN;
				end
			end
			default: begin
				state_reg <= S_RUN;
			end
			endcase
		end
	end

endmodule // csi_core

`default_nettype wire

// [src/csi_consts.vh]
`ifndef CSI_CONSTS_VH
`define CSI_CONSTS_VH

// Interrupt sources and which of them are level-type (no flag).
`define CSI_NIRQ 8
`define CSI_LEVEL_MASK 8'h80

// Register file mapping into the low data space.
`define CSI_REG_TOP 16'h001f
`define CSI_X_LO 5'h1a
`define CSI_Y_LO 5'h1c
`define CSI_Z_LO 5'h1e

// Pointer addressing modes.
`define CSI_PM_PLAIN 2'h0
`define CSI_PM_DISP 2'h1
`define CSI_PM_POSTINC 2'h2
`define CSI_PM_PREDEC 2'h3

// I/O addresses of the core registers.
`define CSI_IO_GENERAL_IRQ_CONTROL_REG 6'h3b
`define CSI_IO_SPL 6'h3d
`define CSI_IO_SPH 6'h3e
`define CSI_IO_STATUS_REG 6'h3f

// Field positions.
`define CSI_GIE_BIT 7
`define CSI_VECTOR_RELOCATE_BIT_BIT 1

// Reset values and implemented stack pointer bits.
`define CSI_SP_RST 16'h0000
`define CSI_SP_MASK 16'h07ff
`define CSI_VECTOR_RELOCATE_BIT_RST 1'h0

// Program memory vector layout.
`define CSI_APP_START 12'h000
`define CSI_BOOT_START 12'hc00
`define CSI_VEC_STRIDE 12'h001

// Sequence lengths in CPU clock cycles, counted from zero.
`define CSI_ENTRY_LAST 3'h3
`define CSI_IRQ_RETURN_OP_LAST 3'h3
`define CSI_WAKE_LAST 3'h3

`endif

// [src/csi_ptr_step.v]
`timescale 1ns/10ps
`default_nettype none

// Effective address and written-back value of one pointer pair.
module csi_ptr_step (
	// Pointer value and mode
	input wire [15:0] ptr_i,
	input wire [1:0] mode_i,
	input wire [5:0] disp_i,
	// Results
	output reg [15:0] ea_o,
	output reg [15:0] next_o
);

`include "csi_consts.vh"

	// Displacement leaves the pair alone; increment and decrement do not.
	always @* begin
		ea_o = ptr_i;
		next_o = ptr_i;
		case (mode_i)
		`CSI_PM_DISP: begin
			ea_o = ptr_i + {10'h000, disp_i};
		end
		`CSI_PM_POSTINC: begin
			next_o = ptr_i + 16'h0001;
		end
		`CSI_PM_PREDEC: begin
			ea_o = ptr_i - 16'h0001;
			next_o = ptr_i - 16'h0001;
		end
		default: begin
			ea_o = ptr_i;
		end
		endcase
	end

endmodule // csi_ptr_step

`default_nettype wire

// [src/csi_irq_pick.v]
`timescale 1ns/10ps
`default_nettype none

// Fixed priority pick: the lowest index, the lowest vector, wins.
module csi_irq_pick #(
	parameter N = 8
) (
	// Requests
	input wire [N-1:0] req_i,
	// Winner
	output reg [N-1:0] grant_o,
	output reg [7:0] index_o,
	output wire any_o
);

	integer i;

	// Scan downward so the last hit, the lowest index, stays.
	always @* begin
		grant_o = {N{1'b0}};
		index_o = 8'h00;
		for (i = N - 1; i >= 0; i = i - 1) begin
			if (req_i[i]) begin
				grant_o = {N{1'b0}};
				grant_o[i] = 1'b1;
				index_o = i[7:0];
			end
		end
	end

	assign any_o = |req_i;

endmodule // csi_irq_pick

`default_nettype wire

// [test/csi_core_sva.sv]
`timescale 1ns/10ps
`default_nettype none
`include "csi_consts.vh"

// Watches stack pointer moves and the entry and return sequences.
module csi_core_sva (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Instruction stream
	input wire logic instr_bound_i,
	input wire logic op_push_i,
	input wire logic op_pop_i,
	input wire logic op_call_i,
	input wire logic op_ret_i,
	input wire logic op_irq_return_op_i,
	input wire logic op_cli_i,
	input wire logic sleeping_i,
	// Core outputs
	input wire logic stk_we_o,
	input wire logic stk_re_o,
	input wire logic core_hold_o,
	input wire logic pc_load_o,
	input wire logic global_irq_en_o,
	input wire logic [15:0] sp_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	// Ops are judged only where no interrupt take can mix in.
	wire logic ok;
	assign ok = !core_hold_o && !global_irq_en_o;
	sequence push_pc;
		stk_we_o ##1 stk_we_o ##1 !stk_we_o;
	endsequence
	sequence pop_pc;
		stk_re_o ##1 stk_re_o;
	endsequence

	chk_push_step: assert property (ok && op_push_i |=>
		stk_we_o && sp_o == (($past(sp_o) - 16'h1) & `CSI_SP_MASK))
		else $error("push step wrong");
	chk_pop_step: assert property (ok && op_pop_i && !op_push_i |=>
		stk_re_o && sp_o == (($past(sp_o) + 16'h1) & `CSI_SP_MASK))
		else $error("pop step wrong");
	chk_call_step: assert property (ok && op_call_i && !op_push_i &&
		!op_pop_i |=> sp_o == (($past(sp_o) - 16'h2) & `CSI_SP_MASK))
		else $error("call step wrong");
	chk_ret_step: assert property (ok && op_ret_i && !op_push_i &&
		!op_pop_i && !op_call_i |=>
		sp_o == (($past(sp_o) + 16'h2) & `CSI_SP_MASK))
		else $error("ret step wrong");
	chk_entry_seq: assert property ($fell(global_irq_en_o) &&
		core_hold_o && !$past(sleeping_i) |-> ##1 push_pc ##1
		(pc_load_o && !core_hold_o))
		else $error("entry sequence wrong");
	// From sleep the four wake cycles come before the pushes.
	chk_wake_entry: assert property ($fell(global_irq_en_o) &&
		core_hold_o && $past(sleeping_i) |-> ##5 push_pc ##1
		(pc_load_o && !core_hold_o))
		else $error("wake entry sequence wrong");
	chk_irq_return_op_seq: assert property (op_irq_return_op_i && instr_bound_i &&
		!core_hold_o |=> core_hold_o ##1 pop_pc ##2 (pc_load_o &&
		global_irq_en_o && sp_o == (($past(sp_o, 5) + 16'h2) & 16'h07ff)))
		else $error("return sequence wrong");
	chk_cli_now: assert property (op_cli_i && !core_hold_o |=>
		!global_irq_en_o && !core_hold_o)
		else $error("take after disable");
	chk_one_instr: assert property ($rose(global_irq_en_o) |=>
		!core_hold_o)
		else $error("take without one instruction");
endmodule // csi_core_sva

bind csi_core csi_core_sva u_chk (.clock_i, .rst_n_i, .instr_bound_i,
	.op_push_i, .op_pop_i, .op_call_i, .op_ret_i, .op_irq_return_op_i, .op_cli_i,
	.sleeping_i,
	.stk_we_o, .stk_re_o, .core_hold_o, .pc_load_o, .global_irq_en_o, .sp_o);
`default_nettype wire

// [test/csi_stack_mem.sv]
`timescale 1ns/10ps
`default_nettype none

// Stack SRAM beside the core; read data comes the cycle after the strobe.
module csi_stack_mem (
	// Clock
	input wire logic clock_i,
	// Core side
	input wire logic stk_we_i,
	input wire logic stk_re_i,
	input wire logic [15:0] stk_addr_i,
	input wire logic [7:0] stk_wdata_i,
	output var logic [7:0] stk_rdata_o
);
	logic [7:0] mem [0:2047];
	initial stk_rdata_o = 8'h5a;
	// Keeps pushed bytes, the return address included, for later pops.
	always @(posedge clock_i) begin
		if (stk_we_i)
			mem[stk_addr_i[10:0]] <= stk_wdata_i;
	end
	// Outside a read the bus toggles, so stale data is never taken as good.
	always @(posedge clock_i) begin
		if (stk_re_i)
			stk_rdata_o <= mem[stk_addr_i[10:0]];
		else
			stk_rdata_o <= ~stk_rdata_o;
	end
endmodule // csi_stack_mem
`default_nettype wire

// [test/cpu_stack_interrupt_core_test.sv]
`timescale 1ns/10ps
`default_nettype none
`include "csi_consts.vh"

module cpu_stack_interrupt_core_test;
	logic clock_i, rst_n_i, rf_wr_en_i, rf_wr_wide_i, ds_wr_i, ptr_go_i;
	logic io_wr_i, io_rd_i, instr_bound_i, sleeping_i, boot_reset_fuse_i;
	logic app_lock_setting_i, boot_lock_setting_i;
	logic [1:0] ptr_sel_i, ptr_mode_i;
	logic [3:0] rf_rd_w_pair_i;
	logic [4:0] rf_rd_a_addr_i, rf_rd_b_addr_i, rf_wr_addr_i, lo;
	logic [5:0] ptr_disp_i, io_addr_i;
	logic [6:0] alu_flags_i, ops;
	logic [7:0] ds_wdata_i, io_wdata_i, push_data_i, stk_rdata_i;
	logic [7:0] irq_event_i, irq_level_i, irq_enable_i, irq_flag_w1c_i;
	logic [11:0] pc_i;
	logic [15:0] rf_wr_data_i, ds_addr_i, sp_m, b;
	logic [31:0] seed;
	logic [7:0] rf_m [32];
	int errors = 0;
	int total_checks = 0;
	int dl [4] = '{-1, 1, -2, 2};
	wire logic [7:0] rf_rd_a_o, rf_rd_b_o, ds_rdata_o, io_rdata_o;
	wire logic [7:0] stk_wdata_o, irq_flags_o;
	wire logic [11:0] pc_load_addr_o, reset_vec_o;
	wire logic [15:0] rf_rd_w_o, ptr_ea_o, stk_addr_o, sp_o;
	wire logic ds_hit_o, stk_we_o, stk_re_o, core_hold_o, pc_load_o;
	wire logic global_irq_en_o;

	csi_core DUT (.clock_i, .rst_n_i, .rf_rd_a_addr_i, .rf_rd_b_addr_i,
		.rf_rd_w_pair_i, .rf_wr_en_i, .rf_wr_wide_i, .rf_wr_addr_i,
		.rf_wr_data_i, .rf_rd_a_o, .rf_rd_b_o, .rf_rd_w_o, .ds_addr_i,
		.ds_wr_i, .ds_wdata_i, .ds_hit_o, .ds_rdata_o, .ptr_go_i, .ptr_sel_i,
		.ptr_mode_i, .ptr_disp_i, .ptr_ea_o, .io_addr_i, .io_wr_i, .io_rd_i,
		.io_wdata_i, .alu_flags_i, .io_rdata_o, .instr_bound_i,
		.op_push_i(ops[0]), .op_pop_i(ops[1]), .op_call_i(ops[2]),
		.op_ret_i(ops[3]), .op_irq_return_op_i(ops[4]), .op_sei_i(ops[5]),
		.op_cli_i(ops[6]), .sleeping_i, .pc_i, .push_data_i, .stk_we_o,
		.stk_re_o, .stk_addr_o, .stk_wdata_o, .stk_rdata_i, .irq_event_i,
		.irq_level_i, .irq_enable_i, .irq_flag_w1c_i, .boot_reset_fuse_i,
		.app_lock_setting_i, .boot_lock_setting_i, .irq_flags_o,
		.core_hold_o, .pc_load_o, .pc_load_addr_o, .reset_vec_o,
		.global_irq_en_o, .sp_o);
	csi_stack_mem u_mem (.clock_i, .stk_we_i(stk_we_o), .stk_re_i(stk_re_o),
		.stk_addr_i(stk_addr_o), .stk_wdata_i(stk_wdata_o),
		.stk_rdata_o(stk_rdata_i));

	// Clock of 20 ns.
	always #10 clock_i = ~clock_i;

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task automatic tick;
		@(posedge clock_i);
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] want);
		total_checks++;
		if (seen !== want) begin
			errors++;
			$display("BAD %0t: got %h want %h", $time, seen, want);
		end
	endtask
	// Pulses are held for one edge only, as the core takes them.
	task automatic op(input logic [6:0] v, input logic [7:0] d);
		tick;
		ops <= v;
		push_data_i <= d;
		tick;
		ops <= 7'h0;
		#1;
	endtask
	task automatic pv(input logic [7:0] ev, input logic [7:0] wc);
		tick;
		irq_event_i <= ev;
		irq_flag_w1c_i <= wc;
		tick;
		{irq_event_i, irq_flag_w1c_i} <= 16'h0;
		#1;
	endtask
	task automatic io(input logic w, input logic [5:0] a, input logic [7:0] d);
		tick;
		{io_wr_i, io_rd_i, io_addr_i, io_wdata_i} <= {w, !w, a, d};
		tick;
		{io_wr_i, io_rd_i} <= 2'b0;
		#1;
	endtask
	// A vector load that never comes ends the run as a failure.
	task automatic wait_load(input logic [11:0] want);
		int n = 0;
		do begin
			tick;
			#1;
			n++;
		end while (pc_load_o !== 1'b1 && n < 40);
		if (pc_load_o !== 1'b1) begin
			errors++;
			wrap_up;
		end
		chk(pc_load_addr_o, want);
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Reset, register file, pointers, stack, then interrupts.
	initial begin
		{clock_i, rst_n_i, rf_wr_en_i, rf_wr_wide_i, ds_wr_i, ptr_go_i, io_wr_i,
			io_rd_i, instr_bound_i, sleeping_i, boot_reset_fuse_i, ptr_sel_i,
			app_lock_setting_i, boot_lock_setting_i, ptr_mode_i, rf_rd_w_pair_i,
			rf_rd_a_addr_i, rf_rd_b_addr_i, rf_wr_addr_i, ptr_disp_i, io_addr_i,
			alu_flags_i, ops, ds_wdata_i, io_wdata_i, push_data_i, irq_event_i,
			irq_level_i, irq_enable_i, irq_flag_w1c_i, pc_i, rf_wr_data_i,
			ds_addr_i} = '0;
		seed = xs(32'hf63bfba5);
		repeat (5) tick;
		{rst_n_i, instr_bound_i} <= 2'b11;
		{alu_flags_i, pc_i} <= seed[18:0];
		#1;
		chk(sp_o, `CSI_SP_RST);
		chk(reset_vec_o, `CSI_APP_START);
		tick;
		boot_reset_fuse_i <= 1'b1;
		io(1'b0, `CSI_IO_STATUS_REG, 8'h0);
		chk(io_rdata_o, {1'b0, alu_flags_i});
		chk(reset_vec_o, `CSI_BOOT_START);
		// Enable bit written through the status register, no source enabled.
		io(1'b1, `CSI_IO_STATUS_REG, 8'h80);
		io(1'b0, `CSI_IO_STATUS_REG, 8'h0);
		chk(io_rdata_o, {1'b1, alu_flags_i});
		io(1'b1, `CSI_IO_STATUS_REG, 8'h00);
		chk(global_irq_en_o, 1'b0);
		// Both write paths, back to back; the last lands past the file.
		for (int i = 0; i < 33; i++) begin
			seed = xs(seed);
			tick;
			rf_wr_en_i <= !i[0] && i < 32;
			ds_wr_i <= i[0] || i == 32;
			{rf_wr_addr_i, ds_addr_i} <= {i[4:0], i[15:0]};
			{rf_wr_data_i, ds_wdata_i} <= {seed[15:0], seed[7:0]};
			if (i < 32)
				rf_m[i] = seed[7:0];
		end
		tick;
		{rf_wr_en_i, ds_wr_i} <= 2'b0;
		for (int i = 0; i < 33; i++) begin
			tick;
			{rf_rd_a_addr_i, rf_rd_b_addr_i} <= {i[4:0], ~i[4:0]};
			{rf_rd_w_pair_i, ds_addr_i} <= {i[4:1], i[15:0]};
			#1;
			chk(rf_rd_a_o, rf_m[i % 32]);
			chk(rf_rd_b_o, rf_m[31 - i % 32]);
			chk(rf_rd_w_o, {rf_m[i % 32 | 1], rf_m[i % 32 & 30]});
			chk(ds_hit_o, i < 32);
			chk(ds_rdata_o, i < 32 ? rf_m[i % 32] : 8'h0);
		end
		// Each addressing mode once, select code equal to the mode: X, Y, then Z twice.
		for (int m = 0; m < 4; m++) begin
			seed = xs(seed);
			b = seed[15:0];
			lo = m[1] ? `CSI_Z_LO : m[0] ? `CSI_Y_LO : `CSI_X_LO;
			tick;
			{rf_wr_en_i, rf_wr_wide_i, rf_wr_addr_i, rf_wr_data_i} <= {2'b11, lo, b};
			tick;
			{rf_wr_en_i, ptr_go_i, ptr_sel_i, ptr_mode_i} <= {2'b01, m[1:0], m[1:0]};
			ptr_disp_i <= seed[21:16];
			#1;
			chk(ptr_ea_o, m == 1 ? b + seed[21:16] : m == 3 ? b - 16'h1 : b);
			tick;
			{ptr_go_i, rf_rd_w_pair_i} <= {1'b0, lo[4:1]};
			#1;
			chk(rf_rd_w_o, m == 2 ? b + 16'h1 : m == 3 ? b - 16'h1 : b);
		end
		// Stack moves from a random start.
		io(1'b1, `CSI_IO_SPH, seed[15:8]);
		io(1'b1, `CSI_IO_SPL, seed[7:0]);
		sp_m = seed[15:0] & `CSI_SP_MASK;
		io(1'b0, `CSI_IO_SPH, 8'h0);
		chk(io_rdata_o, sp_m[15:8]);
		for (int k = 0; k < 4; k++) begin
			b = sp_m;
			op(7'h1 << k, seed[7:0]);
			sp_m = 16'(sp_m + dl[k]) & `CSI_SP_MASK;
			chk(sp_o, sp_m);
			chk({stk_we_o, stk_re_o}, {k == 0, k == 1});
			chk(stk_wdata_o, seed[7:0]);
			if (k < 3)
				chk(stk_addr_o, k == 1 ? b + 16'h1 : b);
		end
		// The stack is placed before any interrupt is enabled.
		io(1'b1, `CSI_IO_SPH, 8'h04);
		io(1'b1, `CSI_IO_SPL, 8'h5f);
		tick;
		irq_enable_i <= 8'h87;
		pv(8'h07, 8'h0);
		pv(8'h0, 8'h01);
		chk(irq_flags_o, 8'h06);
		op(7'h20, 8'h0);
		wait_load(12'h002);
		chk(irq_flags_o, 8'h04);
		chk(sp_o, 16'h045d);
		chk(global_irq_en_o, 1'b0);
		tick;
		irq_level_i <= 8'h80;
		op(7'h10, 8'h0);
		wait_load(pc_i);
		chk(sp_o, 16'h045f);
		wait_load(12'h003);
		op(7'h10, 8'h0);
		wait_load(pc_i);
		wait_load(12'h008);
		tick;
		irq_level_i <= 8'h0;
		op(7'h10, 8'h0);
		wait_load(pc_i);
		op(7'h40, 8'h0);
		chk(global_irq_en_o, 1'b0);
		tick;
		irq_level_i <= 8'h80;
		repeat (3) tick;
		irq_level_i <= 8'h0;
		op(7'h20, 8'h0);
		repeat (12) begin
			tick;
			#1;
			chk(core_hold_o, 1'b0);
		end
		// A boot lock holds requests off while the PC sits in boot with the vectors at the application start.
		tick;
		{boot_lock_setting_i, pc_i} <= {1'b1, 12'hc10};
		pv(8'h01, 8'h0);
		repeat (4) begin
			tick;
			#1;
			chk(core_hold_o, 1'b0);
		end
		chk(irq_flags_o, 8'h01);
		// Released while asleep, so the wake cycles come first.
		tick;
		{boot_lock_setting_i, sleeping_i} <= 2'b01;
		wait_load(12'h001);
		tick;
		sleeping_i <= 1'b0;
		op(7'h10, 8'h0);
		wait_load(12'hc10);
		io(1'b1, `CSI_IO_GENERAL_IRQ_CONTROL_REG, 8'h02);
		pv(8'h01, 8'h0);
		wait_load(`CSI_BOOT_START + `CSI_VEC_STRIDE);
		wrap_up;
	end
endmodule // cpu_stack_interrupt_core_test
`default_nettype wire
